// ===== rtl/memory_copy_relay.sv
// Memory copy relay: holding register, width select and interrupt logic
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Transmit channel deposits, receive channel fetches holding word
// - Width field picks byte, halfword or word
// - Mode resets to word width
// - Enable register writes of one set mask
// - Disable register writes of one clear mask
// - Mask register reads enables, resets to zero
// - Status bit 0 follows end flag
// - Status bit 1 follows full flag
// - Upper offsets reserved, left to DMA or used by event status and clear
// - Either flag rising marks transfer complete
// - Idle holding register is plain software storage
module memory_copy_relay import mcr_pkg::*; (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transmit channel deposit
  input wire logic dma_tx_valid,
  input wire logic [31:0] dma_tx_data,
  // Receive channel fetch and flags
  output logic [31:0] dma_rx_data,
  output logic [1:0] element_width_sel,
  input wire logic rx_end_flag,
  input wire logic rx_full_flag,
  // Events
  output logic transfer_done,
  output logic irq
);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_word;
  logic [31:0] hold_word, next_hold_word;
  logic [1:0] next_width;
  logic [1:0] mask, next_mask;
  logic [1:0] status, rise, sticky, evt_clr;
  logic next_done, next_irq;

  // Element trimmed to the selected width
  function automatic logic [31:0] trim(input logic [1:0] w, input logic [31:0] d);
    case (w)
      WIDTH_BYTE: trim = {24'h00_0000, d[7:0]};
      WIDTH_HALFWORD: trim = {16'h0000, d[15:0]};
      default: trim = d;
    endcase
  endfunction

  // Byte-lane merge for software writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // Write strobe for one register
  function automatic logic hit(input logic en, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = en && (a == ofs);
  endfunction

  axil_port u_port (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rd_word(rd_word),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb)
  );

  // Responses are always OKAY; unmapped space simply reads zero
  assign s_axi_bresp = AXI_OKAY;
  assign s_axi_rresp = AXI_OKAY;

  assign evt_clr = hit(wr_en, wr_addr, OFS_EVT_CLR) ? wr_data[1:0] : 2'h0;

  flag_event #(
    .N(NSRC)
  ) u_flags (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .flag_in({rx_full_flag, rx_end_flag}),
    .clr(evt_clr),
    .level(status),
    .rise(rise),
    .sticky(sticky)
  );

  // Holding register and mode
  always_comb begin
    next_hold_word = hold_word;
    next_width = element_width_sel;
    if (hit(wr_en, wr_addr, OFS_HOLD)) begin
      next_hold_word = merge(hold_word, wr_data, wr_strb);
    end
    // Channel deposit wins over a software write in the same cycle
    if (dma_tx_valid) begin
      next_hold_word = trim(element_width_sel, dma_tx_data);
    end
    // Code 3 is undefined, so such a write keeps the old width
    if (hit(wr_en, wr_addr, OFS_MODE) && wr_strb[0] &&
        wr_data[WSEL_LSB +: WSEL_W] != 2'h3) begin
      next_width = wr_data[WSEL_LSB +: WSEL_W];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_word <= HOLD_RST;
      element_width_sel <= MODE_RST;
    end else if (ce) begin
      hold_word <= next_hold_word;
      element_width_sel <= next_width;
    end
  end

  // Receive channel sees the holding word from its own flop copy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_rx_data <= HOLD_RST;
    end else if (ce) begin
      dma_rx_data <= next_hold_word;
    end
  end

  // Interrupt mask
  always_comb begin
    next_mask = mask;
    if (hit(wr_en, wr_addr, OFS_IER)) begin
      next_mask = mask | wr_data[1:0];
    end
    if (hit(wr_en, wr_addr, OFS_IDR)) begin
      next_mask = mask & ~wr_data[1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask <= MASK_RST;
    end else if (ce) begin
      mask <= next_mask;
    end
  end

  // Completion pulse and interrupt line
  always_comb begin
    next_done = |rise;
    // Status level keeps the line up while a flag stays active
    next_irq = |((status | sticky) & next_mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      transfer_done <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      transfer_done <= next_done;
      irq <= next_irq;
    end
  end

  // Read decode on the address as offered
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_HOLD: rd_word = hold_word;
      OFS_MODE: rd_word[WSEL_LSB +: WSEL_W] = element_width_sel;
      OFS_IMR: rd_word[1:0] = mask;
      OFS_ISR: rd_word[1:0] = status;
      OFS_EVT_STAT: rd_word[1:0] = sticky;
      // Write-only, reserved and DMA-channel offsets read zero here
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Checks
  logic mode_written;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_written <= 1'b0;
    end else if (ce && hit(wr_en, wr_addr, OFS_MODE)) begin
      mode_written <= 1'b1;
    end
  end

  AST_DEPOSIT_WORD: assert property (@(posedge clk) disable iff (!nrst)
    ce && dma_tx_valid && element_width_sel == WIDTH_WORD
    |=> hold_word == $past(dma_tx_data) && dma_rx_data == $past(dma_tx_data))
    else $error("deposited word not held or not passed to receive side");

  AST_DEPOSIT_BYTE: assert property (@(posedge clk) disable iff (!nrst)
    ce && dma_tx_valid && element_width_sel == WIDTH_BYTE
    |=> hold_word == {24'h00_0000, $past(dma_tx_data[7:0])})
    else $error("byte deposit not trimmed to eight bits");

  AST_MODE_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
    !mode_written |-> element_width_sel == WIDTH_WORD)
    else $error("width left word default without a mode write");

  AST_ENABLE_SET: assert property (@(posedge clk) disable iff (!nrst)
    ce && hit(wr_en, wr_addr, OFS_IER) |=> (mask & $past(wr_data[1:0])) == $past(wr_data[1:0]))
    else $error("enable write did not set mask bits");

  AST_DISABLE_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    ce && hit(wr_en, wr_addr, OFS_IDR) |=> (mask & $past(wr_data[1:0])) == 2'h0)
    else $error("disable write did not clear mask bits");

  AST_STATUS_FOLLOW: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> status == $past({rx_full_flag, rx_end_flag}))
    else $error("status bits do not follow receive flags");

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
    ce && (|(status & next_mask)) |=> irq)
    else $error("interrupt low with an enabled active flag");

  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    ce && (rx_end_flag && !status[BIT_END] || rx_full_flag && !status[BIT_FULL])
    |=> transfer_done)
    else $error("flag rise did not mark completion");

  AST_RSV_READ: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_axi_arvalid && s_axi_arready && s_axi_araddr >= OFS_RSV_LO &&
    s_axi_araddr <= OFS_DMA_HI |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("reserved offset read nonzero");

  AST_HALF_DEPOSIT: assert property (@(posedge clk) disable iff (!nrst)
    ce && dma_tx_valid && element_width_sel == WIDTH_HALFWORD
    |=> hold_word == {16'h0000, $past(dma_tx_data[15:0])})
    else $error("halfword deposit not trimmed to sixteen bits");

  AST_RX_COPY: assert property (@(posedge clk) disable iff (!nrst)
    dma_rx_data == hold_word)
    else $error("receive side copy differs from holding word");

  AST_MODE_LEGAL: assert property (@(posedge clk) disable iff (!nrst)
    ce && hit(wr_en, wr_addr, OFS_MODE) && wr_data[1:0] == 2'h3
    |=> element_width_sel == $past(element_width_sel))
    else $error("undefined width code was accepted");

  AST_SW_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    ce && hit(wr_en, wr_addr, OFS_HOLD) && wr_strb == 4'hf && !dma_tx_valid
    |=> hold_word == $past(wr_data))
    else $error("software write did not land in holding word");

  AST_MASK_KEEP: assert property (@(posedge clk) disable iff (!nrst)
    ce && !hit(wr_en, wr_addr, OFS_IER) && !hit(wr_en, wr_addr, OFS_IDR)
    |=> mask == $past(mask))
    else $error("mask changed without an enable or disable write");

  AST_IRQ_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    ce && next_mask == 2'h0 |=> !irq)
    else $error("interrupt high with every source disabled");

  AST_DONE_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    ce && !(rx_end_flag && !status[BIT_END]) && !(rx_full_flag && !status[BIT_FULL])
    |=> !transfer_done)
    else $error("completion pulse without a flag rise");

  AST_FREEZE: assert property (@(posedge clk) disable iff (!nrst)
    !ce |=> $stable(status) && $stable(hold_word) && $stable(mask))
    else $error("state moved while the clock enable was low");
endmodule // memory_copy_relay
`default_nettype wire

// ===== rtl/mcr_pkg.sv
// Constants shared by the memory copy relay design
package mcr_pkg;
  localparam int ADDR_W = 9;
  localparam int NSRC = 2;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_HOLD = 9'h000;
  localparam logic [ADDR_W-1:0] OFS_MODE = 9'h004;
  localparam logic [ADDR_W-1:0] OFS_IER = 9'h008;
  localparam logic [ADDR_W-1:0] OFS_IDR = 9'h00c;
  localparam logic [ADDR_W-1:0] OFS_IMR = 9'h010;
  localparam logic [ADDR_W-1:0] OFS_ISR = 9'h014;
  localparam logic [ADDR_W-1:0] OFS_RSV_LO = 9'h018;
  localparam logic [ADDR_W-1:0] OFS_RSV_HI = 9'h0fc;
  localparam logic [ADDR_W-1:0] OFS_DMA_LO = 9'h100;
  localparam logic [ADDR_W-1:0] OFS_DMA_HI = 9'h124;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 9'h130;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLR = 9'h134;
  // Field positions
  localparam int BIT_END = 0;
  localparam int BIT_FULL = 1;
  localparam int WSEL_LSB = 0;
  localparam int WSEL_W = 2;
  // Element width codes
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALFWORD = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;
  // Reset values
  localparam logic [31:0] HOLD_RST = 32'h0000_0000;
  localparam logic [1:0] MODE_RST = WIDTH_WORD;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
endpackage

// ===== rtl/flag_event.sv
// Samples receive channel flags, detects rises and keeps sticky event bits
`timescale 1ns/1ps
`default_nettype none
module flag_event import mcr_pkg::*; #(
  parameter int N = NSRC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Flags and software clear
  input wire logic [N-1:0] flag_in,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] sticky
);
  logic [N-1:0] next_level;
  logic [N-1:0] next_sticky;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      assign next_level[i] = flag_in[i];
      assign rise[i] = flag_in[i] & ~level[i];
      // Set beats a clear landing in the same cycle
      assign next_sticky[i] = rise[i] | (sticky[i] & ~clr[i]);
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level <= '0;
      sticky <= '0;
    end else if (ce) begin
      level <= next_level;
      sticky <= next_sticky;
    end
  end

  AST_STICKY_SET: assert property (@(posedge clk) disable iff (!nrst)
    ce && (|rise) |=> (sticky & $past(rise)) == $past(rise))
    else $error("rising flag did not set its sticky bit");
endmodule // flag_event
`default_nettype wire

// ===== rtl/axil_port.sv
// AXI4-Lite slave handshakes for the register file
`timescale 1ns/1ps
`default_nettype none
module axil_port import mcr_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic rvalid,
  input wire logic rready,
  // Register file side
  input wire logic [31:0] rd_word,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb
);
  logic aw_have, w_have;
  logic next_aw_have, next_w_have, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [31:0] next_wr_data, next_rdata;
  logic [3:0] next_wr_strb;

  assign wr_en = aw_have & w_have & ~bvalid;

  always_comb begin
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_bvalid = bvalid;
    next_rvalid = rvalid;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_rdata = rdata;
    if (awvalid && awready) begin
      next_aw_have = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_have = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (wr_en) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      rdata <= '0;
    end else if (ce) begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      // Ready drops while a half is parked so the payload is never overwritten
      awready <= ~next_aw_have & ~next_bvalid;
      wready <= ~next_w_have & ~next_bvalid;
      arready <= ~next_rvalid;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      rdata <= next_rdata;
    end
  end

  AST_B_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    bvalid && !bready |=> bvalid)
    else $error("write response dropped before it was taken");
endmodule // axil_port
`default_nettype wire

// ===== sim/dma_pair_model.sv
// Behavioural transmit and receive channel pair feeding the relay
`timescale 1ns/1ps
`default_nettype none
module dma_pair_model (
  // Clock
  input wire logic clk,
  // Transmit channel deposit
  output var logic dma_tx_valid,
  output var logic [31:0] dma_tx_data,
  // Receive channel fetch and flags
  input wire logic [31:0] dma_rx_data,
  output var logic rx_end_flag,
  output var logic rx_full_flag
);
  logic [31:0] src [8];
  logic [31:0] dst [8];

  initial begin
    dma_tx_valid = 1'b0;
    dma_tx_data = 32'h0000_0000;
    rx_end_flag = 1'b0;
    rx_full_flag = 1'b0;
  end

  // One count n for both channels, so sizes always match
  task automatic copy(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      dma_tx_valid <= 1'b1;
      dma_tx_data <= src[i];
      @(posedge clk);
      dma_tx_valid <= 1'b0;
      // Stale data would hide a missed deposit, so invert it
      dma_tx_data <= ~src[i];
      @(posedge clk);
      dst[i] = dma_rx_data;
      repeat (gap) @(posedge clk);
    end
  endtask

  task automatic set_flags(input logic end_f, input logic full_f);
    @(posedge clk);
    rx_end_flag <= end_f;
    rx_full_flag <= full_f;
  endtask
endmodule // dma_pair_model
`default_nettype wire

// ===== sim/test_memory_copy_relay.sv
// Testbench for the memory copy relay register block
`timescale 1ns/1ps
`default_nettype none
module test_memory_copy_relay import mcr_pkg::*; ;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rx_data, tx_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wsel;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, end_f, full_f, done, irq, ce;
  int errors = 0;
  int cmp_count = 0;
  int done_cnt = 0;
  logic [8:0] op_a [7] = '{OFS_IER, OFS_IER, OFS_IER, OFS_IDR, OFS_IDR, OFS_IER, OFS_IDR};
  logic [31:0] op_d [7] = '{32'h1, 32'h0, 32'hffff_fffe, 32'h0, 32'h1, 32'h1, 32'h3};
  logic [31:0] op_m [7] = '{32'h1, 32'h1, 32'h3, 32'h3, 32'h2, 32'h3, 32'h0};
  logic [8:0] rsv [6] = '{9'h018, 9'h0fc, 9'h100, 9'h124, 9'h016, 9'h1fc};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) if (done === 1'b1) done_cnt <= done_cnt + 1;

  memory_copy_relay uut (.clk(clk), .nrst(nrst), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dma_tx_valid(tx_valid), .dma_tx_data(tx_data), .dma_rx_data(rx_data),
    .element_width_sel(wsel), .rx_end_flag(end_f), .rx_full_flag(full_f),
    .transfer_done(done), .irq(irq));

  dma_pair_model partner (.clk(clk), .dma_tx_valid(tx_valid), .dma_tx_data(tx_data),
    .dma_rx_data(rx_data), .rx_end_flag(end_f), .rx_full_flag(full_f));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 200) begin
      errors++;
      $display("ERROR at %0t: bus handshake timed out", $time);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check({30'h0, bresp}, 32'h0);
    bready <= 1'b0;
  endtask

  task automatic rchk(input logic [8:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    check(rdata, exp);
    check({30'h0, rresp}, 32'h0);
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] trim(input logic [31:0] d, input int w);
    if (w == 0) return {24'h0, d[7:0]};
    if (w == 1) return {16'h0, d[15:0]};
    return d;
  endfunction

  task automatic flags(input logic e, input logic f);
    partner.set_flags(e, f);
    repeat (4) @(posedge clk);
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 9'h000;
    araddr = 9'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    check(rx_data, 32'h0000_0000);
    check({30'h0, wsel}, 32'h2);
    rchk(OFS_HOLD, 32'h0000_0000);
    rchk(OFS_MODE, 32'h0000_0002);
    rchk(OFS_IMR, 32'h0000_0000);
    rchk(OFS_ISR, 32'h0000_0000);
    $display("test reset finished");
    wr(OFS_HOLD, 32'hcafe_f00d);
    rchk(OFS_HOLD, 32'hcafe_f00d);
    check(rx_data, 32'hcafe_f00d);
    wr(OFS_HOLD, 32'h1122_3344, 4'h2);
    rchk(OFS_HOLD, 32'hcafe_330d);
    $display("test holding finished");
    for (int w = 0; w < 3; w++) begin
      wr(OFS_MODE, w);
      rchk(OFS_MODE, w);
      check({30'h0, wsel}, w);
      for (int i = 0; i < 3; i++) partner.src[i] = 32'h8765_43a1 + i * 32'h1111_1111;
      // Gap grows with width: back-to-back first, slow last
      partner.copy(3, w);
      for (int i = 0; i < 3; i++) check(partner.dst[i], trim(partner.src[i], w));
      rchk(OFS_HOLD, trim(partner.src[2], w));
    end
    wr(OFS_MODE, 32'h3);
    rchk(OFS_MODE, 32'h2);
    $display("test width finished");
    for (int i = 0; i < 7; i++) begin
      wr(op_a[i], op_d[i]);
      rchk(OFS_IMR, op_m[i]);
    end
    rchk(OFS_IER, 32'h0);
    rchk(OFS_IDR, 32'h0);
    $display("test mask finished");
    flags(1'b1, 1'b0);
    check(done_cnt, 1);
    check({31'h0, irq}, 32'h0);
    rchk(OFS_ISR, 32'h1);
    rchk(OFS_EVT_STAT, 32'h1);
    wr(OFS_IER, 32'h1);
    check({31'h0, irq}, 32'h1);
    flags(1'b0, 1'b0);
    rchk(OFS_ISR, 32'h0);
    wr(OFS_EVT_CLR, 32'h3);
    wr(OFS_IDR, 32'h3);
    check({31'h0, irq}, 32'h0);
    flags(1'b0, 1'b1);
    rchk(OFS_ISR, 32'h2);
    check({31'h0, irq}, 32'h0);
    wr(OFS_IER, 32'h2);
    check({31'h0, irq}, 32'h1);
    flags(1'b0, 1'b0);
    rchk(OFS_ISR, 32'h0);
    flags(1'b1, 1'b1);
    check(done_cnt, 3);
    rchk(OFS_ISR, 32'h3);
    rchk(OFS_EVT_STAT, 32'h3);
    flags(1'b0, 1'b0);
    wr(OFS_IDR, 32'h3);
    wr(OFS_EVT_CLR, 32'h3);
    check({31'h0, irq}, 32'h0);
    rchk(OFS_EVT_STAT, 32'h0);
    $display("test events finished");
    foreach (rsv[i]) begin
      wr(rsv[i], 32'hffff_ffff);
      rchk(rsv[i], 32'h0);
    end
    rchk(OFS_HOLD, 32'ha987_65c3);
    rchk(OFS_MODE, 32'h2);
    rchk(OFS_IMR, 32'h0);
    $display("test reserved finished");
    // A deposit while frozen must leave the holding word alone
    ce <= 1'b0;
    partner.src[0] = 32'h0bad_0bad;
    partner.copy(1, 0);
    check(partner.dst[0], 32'ha987_65c3);
    check({30'h0, wsel}, 32'h2);
    ce <= 1'b1;
    rchk(OFS_HOLD, 32'ha987_65c3);
    $display("test freeze finished");
    print_verdict();
  end
endmodule // test_memory_copy_relay
`default_nettype wire
